// File: pmc_pkg.sv
// package for the power mode controller: modes, timing counts, carried groups
`default_nettype none
package pmc_pkg;
  // power modes, gray coded along active -> sleep -> pd0 -> pd1 -> restore
  typedef enum logic [2:0] {
    PMC_ACTIVE  = 3'h0,
    PMC_SLEEP   = 3'h1,
    PMC_PD0     = 3'h3,
    PMC_PD1     = 3'h2,
    PMC_RESTORE = 3'h6
  } pmc_state_t;

  // requested mode codes on the software request port
  localparam logic [1:0] PMC_REQ_SLEEP = 2'h1;
  localparam logic [1:0] PMC_REQ_PD0   = 2'h2;
  localparam logic [1:0] PMC_REQ_PD1   = 2'h3;

  // wake restore times in ns, rate 125 MHz
  localparam int PMC_CLK_NS         = 8;
  localparam int PMC_SLEEP_WAKE_NS  = 80;
  localparam int PMC_PD_WAKE_NS     = 2000;
  localparam int PMC_SLEEP_WAKE_CYC = (PMC_SLEEP_WAKE_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
  localparam int PMC_PD_WAKE_CYC    = (PMC_PD_WAKE_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
  localparam int PMC_CNT_W          = 9;

  // wake sources, one bit each
  typedef struct packed {
    logic cap_sense;
    logic comparator;
    logic rtc;
    logic sleep_timer;
    logic pin_int;
    logic periph_int;
  } pmc_wake_t;

  // software keep-alive selections while in reduced power
  typedef struct packed {
    logic keep_32k;
    logic keep_comparator;
    logic keep_periph;
  } pmc_keep_t;

  // gating outputs
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic clk_32k_en;
    logic main_pwr_en;
    logic flash_analog_en;
    logic comparator_en;
    logic rtc_cap_radio_en;
    logic pin_hold;
  } pmc_gate_t;

  localparam pmc_gate_t PMC_GATE_ACTIVE = 8'hf6;
endpackage
`default_nettype wire

// File: pmc_power_mode_controller.sv
// power mode controller: mode sequencing, clock and power gating, supply drop monitor
//
// How it works
// RULE1 - any reset puts the chip in active mode with processor clock running
// RULE2 - reduced power entered only on a software request after processing ends
// RULE3 - sleep stops processor clock until reset or interrupt
// RULE4 - in sleep, selected peripherals stay clocked and their interrupts wake
// RULE5 - sleep keeps state, sram, registers and holds pin levels static
// RULE6 - power-down 0 powers only always-on domain, 32k sources, timers, reset pin
// RULE7 - power-down 0 stops clocks except optional 32k; analog and flash off
// RULE8 - comparator may run in power-down and wakes on voltage above reference
// RULE9 - power-down 0 wake: pins, sleep timer, rtc, supply drop, comparator, cap sense
// RULE10 - power-down 0 keeps state and sram, holds pin levels
// RULE11 - waking from power-down takes longer than waking from sleep
// RULE12 - power-down 1 stops 32k source, cap sense, rtc and radio low-power domain
// RULE13 - only pins and comparator wake from power-down 1
// RULE14 - supply drop below level sets a flag that can interrupt
// RULE15 - separate selectable thresholds for reset and for interrupt
// RULE16 - supply drop monitor disabled after reset until software enables it
// RULE17 - on wake, clocks and power restored before processor resumes
`default_nettype none
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int SLEEP_WAKE_CYC = PMC_SLEEP_WAKE_CYC,
  parameter int PD_WAKE_CYC    = PMC_PD_WAKE_CYC,
  parameter int THR_W          = 3
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             mode_req_valid,
  input  wire logic [1:0]       mode_req,
  input  wire logic             cpu_idle,
  input  wire pmc_keep_t        keep,
  input  wire pmc_wake_t        wake_raw,
  input  wire logic             comparator_above,
  input  wire logic             supply_drop_enable,
  input  wire logic [THR_W-1:0] supply_level,
  input  wire logic [THR_W-1:0] reset_threshold,
  input  wire logic [THR_W-1:0] int_threshold,
  input  wire logic             supply_drop_flag_clear,
  output var pmc_gate_t         gate,
  output var pmc_state_t        mode,
  output logic                  cpu_run,
  output logic                  supply_drop_flag,
  output logic                  supply_drop_irq,
  output logic                  supply_drop_reset
);

  initial begin
    // the restore check below bounds the wake at 300 cycles
    if (SLEEP_WAKE_CYC < 1 || PD_WAKE_CYC <= SLEEP_WAKE_CYC || PD_WAKE_CYC > 299)
      $error("pmc: wake counts out of range");
    if (THR_W < 1 || THR_W > 8)
      $error("pmc: threshold width out of range");
  end

  // pin-side inputs pass two flops; only stage two is read
  pmc_wake_t        wake_s1, wake_s2;
  logic             cmp_s1, cmp_s2;
  logic [THR_W-1:0] lvl_s1, lvl_s2;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wake_s1 <= '0;
      wake_s2 <= '0;
      cmp_s1  <= 1'b0;
      cmp_s2  <= 1'b0;
      lvl_s1  <= '1;
      lvl_s2  <= '1;
    end else begin
      wake_s1 <= wake_raw;
      wake_s2 <= wake_s1;
      cmp_s1  <= comparator_above;
      cmp_s2  <= cmp_s1;
      lvl_s1  <= supply_level;
      lvl_s2  <= lvl_s1;
    end
  end

  // supply drop monitor
  logic next_flag, next_irq, next_rst;
  logic below_int, below_rst;

  always_comb begin
    below_int = supply_drop_enable && (lvl_s2 < int_threshold);   // RULE15
    below_rst = supply_drop_enable && (lvl_s2 < reset_threshold); // RULE15
    next_flag = supply_drop_flag;
    if (supply_drop_flag_clear)
      next_flag = 1'b0;
    if (below_int)
      next_flag = 1'b1; // RULE14
    next_irq = next_flag;  // RULE14
    next_rst = below_rst;  // RULE15
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      supply_drop_flag  <= 1'b0; // RULE16
      supply_drop_irq   <= 1'b0;
      supply_drop_reset <= 1'b0;
    end else begin
      supply_drop_flag  <= next_flag;
      supply_drop_irq   <= next_irq;
      supply_drop_reset <= next_rst;
    end
  end

  // wake qualification per mode
  logic wake_sleep, wake_pd0, wake_pd1, cmp_wake;

  always_comb begin
    // the comparator wakes by its level or by its interrupt line
    cmp_wake   = keep.keep_comparator && (cmp_s2 || wake_s2.comparator); // RULE8 RULE9
    wake_sleep = wake_s2.pin_int || (keep.keep_periph && wake_s2.periph_int) // RULE4
                 || wake_s2.sleep_timer || wake_s2.rtc || cmp_wake || supply_drop_irq; // RULE3
    wake_pd0   = wake_s2.pin_int || wake_s2.sleep_timer || wake_s2.rtc || cmp_wake
                 || wake_s2.cap_sense || supply_drop_reset; // RULE9
    wake_pd1   = wake_s2.pin_int || cmp_wake; // RULE13
  end

  // mode sequencer
  pmc_state_t           next_mode;
  pmc_gate_t            next_gate;
  logic                 next_cpu_run;
  logic [PMC_CNT_W-1:0] cnt, next_cnt;

  always_comb begin
    next_mode    = mode;
    next_cnt     = cnt;
    case (mode)
      PMC_ACTIVE: begin
        if (mode_req_valid && cpu_idle) begin // RULE2
          case (mode_req)
            PMC_REQ_SLEEP: next_mode = PMC_SLEEP;
            PMC_REQ_PD0:   next_mode = PMC_PD0;
            PMC_REQ_PD1:   next_mode = PMC_PD1;
            default:       next_mode = PMC_ACTIVE;
          endcase
        end
      end
      PMC_SLEEP: begin
        if (wake_sleep) begin
          next_mode = PMC_RESTORE;
          next_cnt  = PMC_CNT_W'(SLEEP_WAKE_CYC); // RULE11
        end
      end
      PMC_PD0: begin
        if (wake_pd0) begin
          next_mode = PMC_RESTORE;
          next_cnt  = PMC_CNT_W'(PD_WAKE_CYC); // RULE11
        end
      end
      PMC_PD1: begin
        if (wake_pd1) begin
          next_mode = PMC_RESTORE;
          next_cnt  = PMC_CNT_W'(PD_WAKE_CYC); // RULE11
        end
      end
      PMC_RESTORE: begin
        // processor stays stopped until the restore count is spent
        if (cnt <= PMC_CNT_W'(1)) begin
          next_mode = PMC_ACTIVE; // RULE17
          next_cnt  = '0;
        end else begin
          next_cnt = cnt - PMC_CNT_W'(1);
        end
      end
      default: next_mode = PMC_ACTIVE;
    endcase

    // gating follows the mode being entered so outputs stay registered
    next_gate = PMC_GATE_ACTIVE;
    case (next_mode)
      PMC_SLEEP: begin
        next_gate.cpu_clk_en      = 1'b0;               // RULE3
        next_gate.periph_clk_en   = keep.keep_periph;   // RULE4
        next_gate.comparator_en   = keep.keep_comparator;
        next_gate.pin_hold        = 1'b1;               // RULE5
      end
      PMC_PD0: begin
        next_gate.cpu_clk_en      = 1'b0;
        next_gate.periph_clk_en   = 1'b0;               // RULE7
        next_gate.clk_32k_en      = keep.keep_32k;      // RULE7
        next_gate.main_pwr_en     = 1'b0;               // RULE6
        next_gate.flash_analog_en = 1'b0;               // RULE7
        next_gate.comparator_en   = keep.keep_comparator; // RULE8
        next_gate.rtc_cap_radio_en = 1'b1;              // RULE6
        next_gate.pin_hold        = 1'b1;               // RULE10
      end
      PMC_PD1: begin
        next_gate.cpu_clk_en      = 1'b0;
        next_gate.periph_clk_en   = 1'b0;
        next_gate.clk_32k_en      = 1'b0;               // RULE12
        next_gate.main_pwr_en     = 1'b0;
        next_gate.flash_analog_en = 1'b0;
        next_gate.comparator_en   = keep.keep_comparator; // RULE8
        next_gate.rtc_cap_radio_en = 1'b0;              // RULE12
        next_gate.pin_hold        = 1'b1;
      end
      PMC_RESTORE: begin
        // power and clocks back on, pins still held, cpu still stopped
        next_gate.cpu_clk_en      = 1'b0; // RULE17
        next_gate.pin_hold        = 1'b1;
      end
      default: next_gate = PMC_GATE_ACTIVE;
    endcase
    next_cpu_run = (next_mode == PMC_ACTIVE);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode    <= PMC_ACTIVE;      // RULE1
      gate    <= PMC_GATE_ACTIVE; // RULE1
      cpu_run <= 1'b1;
      cnt     <= '0;
    end else begin
      mode    <= next_mode;
      gate    <= next_gate;
      cpu_run <= next_cpu_run;
      cnt     <= next_cnt;
    end
  end

  // checks
  sequence s_wake_pd0;
    mode == PMC_PD0 && wake_pd0;
  endsequence

  sequence s_restore_done;
    (mode == PMC_RESTORE) [*1] ##[1:300] (mode == PMC_ACTIVE);
  endsequence

  reset_active_a: assert property (@(posedge mclk) $fell(sys_rst) |-> mode == PMC_ACTIVE && cpu_run) // RULE1
    else $error("not active after reset");
  entry_req_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mode == PMC_ACTIVE && !(mode_req_valid && cpu_idle)) |=> mode == PMC_ACTIVE) // RULE2
    else $error("left active without request");
  sleep_clk_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == PMC_SLEEP |-> !gate.cpu_clk_en && !cpu_run && gate.pin_hold) // RULE3
    else $error("cpu clocked in sleep");
  sleep_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == PMC_SLEEP |-> gate.periph_clk_en == $past(keep.keep_periph)) // RULE4
    else $error("peripheral clock selection lost");
  pd0_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == PMC_PD0 |-> !gate.main_pwr_en && !gate.flash_analog_en && gate.pin_hold) // RULE7
    else $error("power-down 0 gating wrong");
  pd1_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == PMC_PD1 |-> !gate.clk_32k_en && !gate.rtc_cap_radio_en) // RULE12
    else $error("power-down 1 gating wrong");
  pd1_wake_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mode == PMC_PD1 && !wake_s2.pin_int && !cmp_wake) |=> mode == PMC_PD1) // RULE13
    else $error("illegal wake from power-down 1");
  pd0_wake_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_wake_pd0 |=> s_restore_done) // RULE9
    else $error("power-down 0 wake not completed");
  restore_cpu_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == PMC_RESTORE |-> !cpu_run && gate.main_pwr_en) // RULE17
    else $error("cpu ran before restore");
  wake_time_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(mode == PMC_RESTORE) && $past(mode) == PMC_SLEEP |-> cnt == PMC_CNT_W'(SLEEP_WAKE_CYC)) // RULE11
    else $error("sleep wake count wrong");
  drop_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    below_int |=> supply_drop_flag ##1 supply_drop_irq) // RULE14
    else $error("supply drop flag not set");
  drop_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !supply_drop_enable [*3] |-> !supply_drop_reset) // RULE16
    else $error("monitor acted while disabled");

endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the power mode controller, ports driven directly
`default_nettype none
module tb_top;
  import pmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SW = 2;
  localparam int PW = 5;
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       mode_req_valid = 1'b0;
  logic [1:0] mode_req = 2'h0;
  logic       cpu_idle = 1'b0;
  pmc_keep_t  keep = 3'h0;
  pmc_wake_t  wake_raw = 6'h00;
  logic       comparator_above = 1'b0;
  logic       supply_drop_enable = 1'b0;
  logic [2:0] supply_level = 3'h7;
  logic [2:0] reset_threshold = 3'h2;
  logic [2:0] int_threshold = 3'h4;
  logic       supply_drop_flag_clear = 1'b0;
  pmc_gate_t  gate;
  pmc_state_t mode;
  logic       cpu_run;
  logic       supply_drop_flag;
  logic       supply_drop_irq;
  logic       supply_drop_reset;
  int         bad_count = 0;
  int         comparisons = 0;
  int         n = 0;
  int         ns_sleep = 0;

  pmc_power_mode_controller #(.SLEEP_WAKE_CYC(SW), .PD_WAKE_CYC(PW), .THR_W(3)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .mode_req_valid(mode_req_valid), .mode_req(mode_req),
    .cpu_idle(cpu_idle), .keep(keep), .wake_raw(wake_raw), .comparator_above(comparator_above),
    .supply_drop_enable(supply_drop_enable), .supply_level(supply_level),
    .reset_threshold(reset_threshold), .int_threshold(int_threshold),
    .supply_drop_flag_clear(supply_drop_flag_clear), .gate(gate), .mode(mode), .cpu_run(cpu_run),
    .supply_drop_flag(supply_drop_flag), .supply_drop_irq(supply_drop_irq),
    .supply_drop_reset(supply_drop_reset));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // request is held one cycle only; the level is sampled every edge
  task automatic enter(input logic [1:0] req, input logic idle);
    mode_req_valid = 1'b1;
    mode_req = req;
    cpu_idle = idle;
    cyc(1);
    mode_req_valid = 1'b0;
    cpu_idle = 1'b0;
  endtask

  // raise wake inputs, count edges until active again; sync and restore included
  task automatic wake(input logic [5:0] w, input logic cmp, output int k);
    wake_raw = pmc_wake_t'(w);
    comparator_above = cmp;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (mode !== PMC_ACTIVE && k < 400);
    wake_raw = 6'h00;
    comparator_above = 1'b0;
    cyc(3);
  endtask

  task automatic no_wake(input logic [5:0] w, input pmc_state_t m);
    wake_raw = pmc_wake_t'(w);
    cyc(8);
    chk(32'(mode), 32'(m));
    wake_raw = 6'h00;
    cyc(3);
  endtask

  task automatic t_reset();
    chk(32'(mode), 32'(PMC_ACTIVE));
    chk(32'({cpu_run, gate}), 32'({1'b1, PMC_GATE_ACTIVE}));
    chk(32'({supply_drop_flag, supply_drop_irq, supply_drop_reset}), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_refuse();
    enter(PMC_REQ_SLEEP, 1'b0);
    cyc(1);
    chk(32'(mode), 32'(PMC_ACTIVE));
    enter(2'h0, 1'b1);
    cyc(1);
    chk(32'(mode), 32'(PMC_ACTIVE));
    $display("test refuse done");
  endtask

  task automatic t_sleep();
    keep = 3'h0;
    enter(PMC_REQ_SLEEP, 1'b1);
    chk(32'(mode), 32'(PMC_SLEEP));
    chk(32'({cpu_run, gate.cpu_clk_en, gate.pin_hold}), 32'h1);
    no_wake(6'h01, PMC_SLEEP);
    wake(6'h02, 1'b0, ns_sleep);
    chk(32'(ns_sleep), 32'(3 + SW));
    chk(32'({cpu_run, gate}), 32'({1'b1, PMC_GATE_ACTIVE}));
    keep = 3'h1;
    enter(PMC_REQ_SLEEP, 1'b1);
    chk(32'(gate.periph_clk_en), 32'h1);
    wake(6'h01, 1'b0, n);
    chk(32'(n), 32'(3 + SW));
    $display("test sleep done");
  endtask

  task automatic t_pd0();
    logic [5:0] src [5] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    keep = 3'h6;
    for (int i = 0; i < 5; i++) begin
      enter(PMC_REQ_PD0, 1'b1);
      chk(32'(mode), 32'(PMC_PD0));
      chk(32'({gate.cpu_clk_en, gate.periph_clk_en, gate.main_pwr_en}), 32'h0);
      chk(32'({gate.clk_32k_en, gate.flash_analog_en, gate.comparator_en}), 32'h5);
      chk(32'({cpu_run, gate.pin_hold}), 32'h1);
      if (i == 0) begin
        no_wake(6'h01, PMC_PD0);
      end
      wake(src[i], 1'b0, n);
      chk(32'(n), 32'(3 + PW));
      chk(32'(n > ns_sleep), 32'h1);
    end
    keep = 3'h2;
    enter(PMC_REQ_PD0, 1'b1);
    chk(32'(gate.clk_32k_en), 32'h0);
    wake(6'h02, 1'b0, n);
    $display("test power-down 0 done");
  endtask

  task automatic t_pd1();
    keep = 3'h6;
    enter(PMC_REQ_PD1, 1'b1);
    chk(32'(mode), 32'(PMC_PD1));
    chk(32'({gate.clk_32k_en, gate.rtc_cap_radio_en, gate.pin_hold}), 32'h1);
    no_wake(6'h2d, PMC_PD1);
    wake(6'h00, 1'b1, n);
    chk(32'(n), 32'(3 + PW));
    enter(PMC_REQ_PD1, 1'b1);
    wake(6'h02, 1'b0, n);
    chk(32'(n), 32'(3 + PW));
    keep = 3'h0;
    $display("test power-down 1 done");
  endtask

  task automatic t_supply();
    supply_level = 3'h1;
    cyc(6);
    chk(32'({supply_drop_flag, supply_drop_irq, supply_drop_reset}), 32'h0);
    supply_level = 3'h7;
    supply_drop_enable = 1'b1;
    cyc(4);
    supply_level = 3'h3;
    cyc(3);
    chk(32'({supply_drop_flag, supply_drop_irq, supply_drop_reset}), 32'h6);
    cyc(1);
    chk(32'(supply_drop_irq), 32'h1);
    supply_level = 3'h7;
    cyc(4);
    chk(32'(supply_drop_flag), 32'h1);
    supply_drop_flag_clear = 1'b1;
    cyc(1);
    supply_drop_flag_clear = 1'b0;
    cyc(1);
    chk(32'(supply_drop_flag), 32'h0);
    // reset threshold last: a forced reset may disturb other state
    supply_level = 3'h1;
    cyc(3);
    chk(32'(supply_drop_reset), 32'h1);
    supply_level = 3'h7;
    cyc(4);
    chk(32'(supply_drop_reset), 32'h0);
    $display("test supply monitor done");
  endtask

  initial begin
    cyc(20);
    sys_rst = 1'b0;
    t_reset();
    t_refuse();
    t_sleep();
    t_pd0();
    t_pd1();
    t_supply();
    print_verdict();
  end

  // whole run is well under a thousand cycles; this only cuts a hang
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
